/* verilog/rssc_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - a slot code from 3h to Ah enables its output when the sequencer reaches that strobe step.
// - a slot code of 0h to 2h or Bh to Fh keeps its output away from every strobe step.
// - the switch and ldo slot register at 0x25 holds the switch slot high and the ldo slot low, reset 0xA7.
// - the general output slot register at 0x26 holds output c high and output a low, reset 0x35.
module rssc_top
   import rssc_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // register port
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [DATA_W-1:0] rd_data_out,
   // sequencer strobe port
   input wire logic [SLOT_W-1:0] strobe_step_in,
   input wire logic strobe_vld_in,
   input wire logic seq_clear_in,
   // rail enables
   output logic ldo_en_out,
   output logic load_switch_en_out,
   output logic gp_output_a_en_out,
   output logic gp_output_c_en_out
);
   // stored state
   logic [DATA_W-1:0] sw_ldo_r;
   logic [DATA_W-1:0] sw_ldo_nxt;
   logic [DATA_W-1:0] gp_out_r;
   logic [DATA_W-1:0] gp_out_nxt;
   logic armed_r;
   logic armed_nxt;
   logic refused_r;
   logic refused_nxt;
   logic [N_RAILS-1:0] rail_en_r;
   logic [N_RAILS-1:0] rail_en_nxt;
   logic [DATA_W-1:0] rd_data_r;
   logic [DATA_W-1:0] rd_data_nxt;

   // address decode
   wire sel_sw_ldo = (addr_in == SW_LDO_ADDR);
   wire sel_gp_out = (addr_in == GP_OUT_ADDR);
   wire sel_unlock = (addr_in == UNLOCK_ADDR);
   wire sel_status = (addr_in == STATUS_ADDR);
   wire slot_sel = sel_sw_ldo | sel_gp_out;

   // write qualification against the unlock state
   wire key_write = wr_in && sel_unlock && (wr_data_in == UNLOCK_KEY);
   wire slot_write_ok = wr_in && slot_sel && armed_r;
   wire slot_write_bad = wr_in && slot_sel && !armed_r;

   // slot fields pulled out of the two registers
   wire [SLOT_W-1:0] load_switch_slot = sw_ldo_r[HI_SLOT_LSB +: SLOT_W];
   wire [SLOT_W-1:0] ldo_slot = sw_ldo_r[LO_SLOT_LSB +: SLOT_W];
   wire [SLOT_W-1:0] gp_output_c_slot = gp_out_r[HI_SLOT_LSB +: SLOT_W];
   wire [SLOT_W-1:0] gp_output_a_slot = gp_out_r[LO_SLOT_LSB +: SLOT_W];

   // per-rail strobe match from the decoder
   rssc_slot_if slot_bus ();
   assign slot_bus.step = strobe_step_in;
   assign slot_bus.step_vld = strobe_vld_in;
   assign slot_bus.slots = {gp_output_c_slot, gp_output_a_slot, load_switch_slot, ldo_slot};

   rssc_slot_decode #(
      .RAILS (N_RAILS)
   ) u_decode (
      .bus (slot_bus)
   );

   // next value of the slot registers; locked writes are dropped
   assign sw_ldo_nxt = (slot_write_ok && sel_sw_ldo) ? wr_data_in : sw_ldo_r;
   assign gp_out_nxt = (slot_write_ok && sel_gp_out) ? wr_data_in : gp_out_r;

   // unlock is good for exactly the next write of any kind
   assign armed_nxt = key_write ? 1'b1 : (wr_in ? 1'b0 : armed_r);

   // refused-write flag, cleared by a status read; a new refusal wins
   assign refused_nxt = slot_write_bad ? 1'b1 : ((rd_in && sel_status) ? 1'b0 : refused_r);

   // enables latch on a matching strobe; a match beats a clear
   assign rail_en_nxt = slot_bus.hit | (seq_clear_in ? '0 : rail_en_r);

   // status word
   wire [DATA_W-1:0] status_word = {2'b00, refused_r, armed_r, rail_en_r};

   // read mux; unmapped addresses read as zero
   wire [DATA_W-1:0] rd_mux = sel_sw_ldo ? sw_ldo_r :
                              sel_gp_out ? gp_out_r :
                              sel_status ? status_word :
                              READ_IDLE;
   assign rd_data_nxt = rd_in ? rd_mux : READ_IDLE;

   // slot registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sw_ldo_r <= SW_LDO_RST;
         gp_out_r <= GP_OUT_RST;
      end else begin
         sw_ldo_r <= sw_ldo_nxt;
         gp_out_r <= gp_out_nxt;
      end
   end

   // unlock and refusal flags
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         armed_r <= 1'b0;
         refused_r <= 1'b0;
      end else begin
         armed_r <= armed_nxt;
         refused_r <= refused_nxt;
      end
   end

   // rail enables and read data
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rail_en_r <= '0;
         rd_data_r <= READ_IDLE;
      end else begin
         rail_en_r <= rail_en_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   // outputs straight from flops
   assign rd_data_out = rd_data_r;
   assign ldo_en_out = rail_en_r[RAIL_LDO];
   assign load_switch_en_out = rail_en_r[RAIL_SWITCH];
   assign gp_output_a_en_out = rail_en_r[RAIL_GP_A];
   assign gp_output_c_en_out = rail_en_r[RAIL_GP_C];

   // checks on register reset values
   property p_reset_values;
      @(posedge clk_in) $rose(nrst_in) |-> (sw_ldo_r == SW_LDO_RST) && (gp_out_r == GP_OUT_RST);
   endproperty
   a_reset_slot_values: assert property (p_reset_values)
      else $error("slot registers not at reset value after reset");

   // the reset codes put the switch at step 10 and the ldo at step 7
   a_reset_field_split: assert property (
      @(posedge clk_in) $rose(nrst_in) |-> (load_switch_slot == 4'hA) && (ldo_slot == 4'h7))
      else $error("switch or ldo slot field misplaced");

   // general output fields decode to steps 3 and 5 out of reset
   a_reset_gp_split: assert property (
      @(posedge clk_in) $rose(nrst_in) |-> (gp_output_c_slot == 4'h3) && (gp_output_a_slot == 4'h5))
      else $error("general output slot field misplaced");

   // unlock sequence: key write then a slot write
   sequence s_key;
      wr_in && sel_unlock && (wr_data_in == UNLOCK_KEY);
   endsequence

   sequence s_unlocked_switch_write;
      s_key ##1 (wr_in && sel_sw_ldo);
   endsequence

   a_unlocked_write_lands: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      s_unlocked_switch_write |=> (sw_ldo_r == $past(wr_data_in)))
      else $error("unlocked slot write did not store");

   // a slot write with no unlock leaves both registers untouched
   a_locked_write_dropped: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (wr_in && slot_sel && !armed_r) |=> $stable(sw_ldo_r) && $stable(gp_out_r) && refused_r)
      else $error("locked slot write changed a register");

   // unlock is consumed by the next write and cannot be reused
   a_unlock_single_use: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      s_key ##1 (wr_in && slot_sel) ##1 (wr_in && sel_gp_out) |=> $stable(gp_out_r))
      else $error("unlock served more than one write");

   // in-window code enables its rail on the matching step
   a_step_enables_rail: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (strobe_vld_in && slot_active(gp_output_c_slot) && (strobe_step_in == gp_output_c_slot))
      |=> gp_output_c_en_out)
      else $error("rail not enabled at its strobe step");

   // out-of-window code never raises its rail
   a_outside_stays_off: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (!slot_active(ldo_slot) && !rail_en_r[RAIL_LDO]) |=> !ldo_en_out)
      else $error("rail enabled with an out-of-window slot code");

   // read data appear one cycle after the strobe and only then
   a_read_one_cycle: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (rd_in && sel_sw_ldo) |=> (rd_data_out == $past(sw_ldo_r)) ##1 ($past(rd_in) || rd_data_out == READ_IDLE))
      else $error("slot register read data wrong or held too long");

   // general output slot read data track the register one cycle on
   a_read_gp_slot: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (rd_in && sel_gp_out) |=> (rd_data_out == $past(gp_out_r)))
      else $error("general output slot read data wrong");

   // no read strobe means idle read data in the next cycle
   a_read_idle_zero: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      !rd_in |=> (rd_data_out == READ_IDLE))
      else $error("read data not idle without a read strobe");

   // reads away from the slot and status registers return idle data
   a_read_unmapped: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (rd_in && !slot_sel && !sel_status) |=> (rd_data_out == READ_IDLE))
      else $error("unmapped read returned data");

   // status read reports unlock, refusal and enables of the strobe cycle
   a_status_read_flags: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (rd_in && sel_status) |=> (rd_data_out[STAT_ARMED_BIT] == $past(armed_r))
         && (rd_data_out[STAT_REFUSED_BIT] == $past(refused_r))
         && (rd_data_out[STAT_EN_LSB +: N_RAILS] == $past(rail_en_r)))
      else $error("status read data do not match the flags");

   // a key write arms the unlock
   a_key_arms: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      s_key |=> armed_r)
      else $error("key write did not arm the unlock");

   // any other write uses up the unlock
   a_write_disarms: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (wr_in && !key_write) |=> !armed_r)
      else $error("unlock survived a write");

   // without a write the unlock state stays put
   a_armed_holds: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      !wr_in |=> $stable(armed_r))
      else $error("unlock state moved without a write");

   // a status read clears the refusal flag
   a_refused_clear: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (rd_in && sel_status && !wr_in) |=> !refused_r)
      else $error("refusal flag not cleared by status read");

   // key write then a general output slot write with no gap
   sequence s_unlocked_gp_write;
      s_key ##1 (wr_in && sel_gp_out);
   endsequence

   a_gp_write_lands: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      s_unlocked_gp_write |=> (gp_out_r == $past(wr_data_in)))
      else $error("unlocked general output write did not store");

   // the switch and ldo slots change only through an unlocked write
   a_switch_ldo_guarded: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      !$stable(sw_ldo_r) |-> ($past(slot_write_ok) && $past(sel_sw_ldo)))
      else $error("switch ldo slots changed without unlock");

   // the general output slots change only through an unlocked write
   a_gp_out_guarded: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      !$stable(gp_out_r) |-> ($past(slot_write_ok) && $past(sel_gp_out)))
      else $error("general output slots changed without unlock");

   // a raised rail stays up until a clear
   a_rail_sticky: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      !seq_clear_in |=> ((rail_en_r & $past(rail_en_r)) == $past(rail_en_r)))
      else $error("rail enable dropped without a clear");

   // a clear with no strobe drops every rail
   a_clear_drops: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (seq_clear_in && !strobe_vld_in) |=> (rail_en_r == '0))
      else $error("clear left a rail enabled");

   // no rail rises without a valid strobe step
   a_no_strobe_rise: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      !strobe_vld_in |=> ((rail_en_r & ~$past(rail_en_r)) == '0))
      else $error("rail rose without a strobe");

   // ldo rail comes up on its own strobe step
   a_ldo_step_enable: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (strobe_vld_in && slot_active(ldo_slot) && (strobe_step_in == ldo_slot))
      |=> ldo_en_out)
      else $error("ldo not enabled at its strobe step");

   // load switch comes up on its own strobe step
   a_switch_step_enable: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (strobe_vld_in && slot_active(load_switch_slot) && (strobe_step_in == load_switch_slot))
      |=> load_switch_en_out)
      else $error("load switch not enabled at its strobe step");

   // general output a comes up on its own strobe step
   a_gpa_step_enable: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (strobe_vld_in && slot_active(gp_output_a_slot) && (strobe_step_in == gp_output_a_slot))
      |=> gp_output_a_en_out)
      else $error("general output a not enabled at its strobe step");

   // out-of-window switch code never raises the switch
   a_switch_outside_off: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (!slot_active(load_switch_slot) && !rail_en_r[RAIL_SWITCH]) |=> !load_switch_en_out)
      else $error("load switch enabled with an out-of-window code");

   // out-of-window code never raises general output a
   a_gpa_outside_off: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (!slot_active(gp_output_a_slot) && !rail_en_r[RAIL_GP_A]) |=> !gp_output_a_en_out)
      else $error("general output a enabled with an out-of-window code");

   // out-of-window code never raises general output c
   a_gpc_outside_off: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (!slot_active(gp_output_c_slot) && !rail_en_r[RAIL_GP_C]) |=> !gp_output_c_en_out)
      else $error("general output c enabled with an out-of-window code");
endmodule

/* pkg/rssc_pkg.sv */
package rssc_pkg;
   // register port shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int SLOT_W = 4;
   localparam int N_RAILS = 4;

   // slot register map
   localparam logic [ADDR_W-1:0] SW_LDO_ADDR = 8'h25;
   localparam logic [ADDR_W-1:0] GP_OUT_ADDR = 8'h26;
   // unlock key port and status, placed next to nothing else
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR = 8'h10;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h11;

   // reset values and the unlock key
   localparam logic [DATA_W-1:0] SW_LDO_RST = 8'hA7;
   localparam logic [DATA_W-1:0] GP_OUT_RST = 8'h35;
   localparam logic [DATA_W-1:0] UNLOCK_KEY = 8'h7D;
   localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

   // field positions inside the slot registers
   localparam int HI_SLOT_LSB = 4;
   localparam int LO_SLOT_LSB = 0;

   // status register fields
   localparam int STAT_EN_LSB = 0;
   localparam int STAT_ARMED_BIT = 4;
   localparam int STAT_REFUSED_BIT = 5;

   // rail index in the enable vector
   localparam int RAIL_LDO = 0;
   localparam int RAIL_SWITCH = 1;
   localparam int RAIL_GP_A = 2;
   localparam int RAIL_GP_C = 3;

   // strobe step window served by the sequencer
   localparam logic [SLOT_W-1:0] SLOT_FIRST = 4'h3;
   localparam logic [SLOT_W-1:0] SLOT_LAST = 4'hA;

   // true when a slot code places its output under the sequencer
   function automatic logic slot_active(input logic [SLOT_W-1:0] code);
      slot_active = (code >= SLOT_FIRST) && (code <= SLOT_LAST);
   endfunction
endpackage

/* pkg/rssc_slot_if.sv */
`timescale 1ns/1ps
interface rssc_slot_if;
   import rssc_pkg::*;
   logic [SLOT_W-1:0] step;
   logic step_vld;
   logic [N_RAILS*SLOT_W-1:0] slots;
   logic [N_RAILS-1:0] hit;
   modport dec (input step, input step_vld, input slots, output hit);
   modport top (output step, output step_vld, output slots, input hit);
endinterface

/* verilog/rssc_slot_decode.sv */
`timescale 1ns/1ps
module rssc_slot_decode
   import rssc_pkg::*;
#(
   parameter int RAILS = N_RAILS
) (
   // strobe step and slot codes in, per-rail match out
   rssc_slot_if.dec bus
);
   // refuse shapes the slot vector cannot carry
   if (RAILS < 1 || RAILS > N_RAILS) begin : g_bad_rails
      $error("rail count out of range");
   end

   // one comparator per rail; codes outside the window never match
   for (genvar i = 0; i < RAILS; i++) begin : g_rail
      wire [SLOT_W-1:0] code = bus.slots[i*SLOT_W +: SLOT_W];
      assign bus.hit[i] = bus.step_vld && slot_active(code) && (code == bus.step);
   end
   for (genvar j = RAILS; j < N_RAILS; j++) begin : g_unused
      assign bus.hit[j] = 1'b0;
   end
endmodule

/* tb/rail_strobe_slot_config_tb.sv */
`timescale 1ns/1ps
module rail_strobe_slot_config_tb
   import rssc_pkg::*;
;
   // clock, reset and register port drive
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wr_data = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [DATA_W-1:0] rd_data;
   // strobe port drive and rail enables
   logic [SLOT_W-1:0] step = 4'h0;
   logic vld = 1'b0;
   logic clr = 1'b0;
   logic ldo_en, sw_en, gpa_en, gpc_en;
   wire logic [3:0] en = {gpc_en, gpa_en, sw_en, ldo_en};
   int mismatches = 0;
   int n_tests = 0;

   rssc_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr), .wr_data_in(wr_data), .wr_in(wr),
      .rd_in(rd), .rd_data_out(rd_data), .strobe_step_in(step), .strobe_vld_in(vld), .seq_clear_in(clr),
      .ldo_en_out(ldo_en), .load_switch_en_out(sw_en), .gp_output_a_en_out(gpa_en),
      .gp_output_c_en_out(gpc_en));

   // 125 MHz clock
   initial begin
      forever #4 clk_in = ~clk_in;
   end

   // compare tasks for register data and for the enable vector
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_en(input logic [3:0] exp);
      n_tests++;
      if (en !== exp) begin
         mismatches++;
         $display("wrong value at %0t: enables %b expected %b", $time, en, exp);
      end
   endtask

   // one-cycle bus strobes
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wr_data <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask
   // key write followed with no gap by one or two more writes
   task automatic wr_keyed(input logic [7:0] a1, input logic [7:0] d1, input logic [7:0] a2,
      input logic [7:0] d2, input bit two);
      @(posedge clk_in);
      addr <= UNLOCK_ADDR;
      wr_data <= UNLOCK_KEY;
      wr <= 1'b1;
      @(posedge clk_in);
      addr <= a1;
      wr_data <= d1;
      if (two) begin
         @(posedge clk_in);
         addr <= a2;
         wr_data <= d2;
      end
      @(posedge clk_in);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic strobe(input logic [3:0] s);
      @(posedge clk_in);
      step <= s;
      vld <= 1'b1;
      @(posedge clk_in);
      vld <= 1'b0;
      #1;
   endtask
   task automatic seq_clear();
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      #1 chk_en(4'h0);
   endtask

   // reset values and an unmapped read
   task automatic t_reset_values();
      logic [7:0] d;
      reg_rd(SW_LDO_ADDR, d);
      chk8(d, 8'hA7, "switch ldo reset");
      @(posedge clk_in);
      #1 chk8(rd_data, READ_IDLE, "read data one cycle only");
      reg_rd(GP_OUT_ADDR, d);
      chk8(d, 8'h35, "gp output reset");
      reg_rd(8'h40, d);
      chk8(d, 8'h00, "unmapped read");
   endtask

   // full step walk with reset slots: gp c at 3, gp a at 5, ldo at 7, switch at 10
   task automatic t_reset_walk();
      for (int s = 0; s < 16; s++) begin
         strobe(s[3:0]);
         chk_en({s >= 3, s >= 5, s >= 10, s >= 7});
      end
      seq_clear();
   endtask

   // writes without a fresh unlock are dropped and flagged
   task automatic t_locked_write();
      logic [7:0] d;
      reg_wr(SW_LDO_ADDR, 8'h00);
      reg_rd(SW_LDO_ADDR, d);
      chk8(d, 8'hA7, "locked write");
      reg_rd(STATUS_ADDR, d);
      chk8(d, 8'h20, "refused flag");
      reg_rd(STATUS_ADDR, d);
      chk8(d, 8'h00, "refused flag cleared");
      reg_wr(UNLOCK_ADDR, UNLOCK_KEY);
      reg_rd(STATUS_ADDR, d); // no status bit is taken as a seal flag
      chk8(d, 8'h10, "unlock armed");
      reg_wr(8'h40, 8'h11);
      reg_wr(GP_OUT_ADDR, 8'h00);
      reg_rd(GP_OUT_ADDR, d);
      chk8(d, 8'h35, "unlock consumed elsewhere");
      wr_keyed(SW_LDO_ADDR, 8'h48, GP_OUT_ADDR, 8'h00, 1'b1);
      reg_rd(SW_LDO_ADDR, d);
      chk8(d, 8'h48, "keyed write");
      reg_rd(GP_OUT_ADDR, d);
      chk8(d, 8'h35, "unlock used once");
      reg_rd(STATUS_ADDR, d);
      chk8(d, 8'h20, "refused after keyed pair");
   endtask

   // every code in every field, swept against every step
   task automatic t_code_sweep();
      logic [7:0] d;
      logic v;
      for (int c = 0; c < 16; c++) begin
         reg_wr(UNLOCK_ADDR, UNLOCK_KEY);
         reg_wr(SW_LDO_ADDR, {c[3:0], c[3:0]});
         wr_keyed(GP_OUT_ADDR, {c[3:0], c[3:0]}, 8'h00, 8'h00, 1'b0);
         reg_rd(SW_LDO_ADDR, d);
         chk8(d, {c[3:0], c[3:0]}, "unlocked write");
         reg_rd(GP_OUT_ADDR, d);
         chk8(d, {c[3:0], c[3:0]}, "unlocked write");
         seq_clear();
         for (int s = 0; s < 16; s++) begin
            strobe(s[3:0]);
            v = (c >= 3) && (c <= 10) && (s >= c);
            chk_en({v, v, v, v});
         end
      end
   endtask

   // reset in mid-run after the slots were moved and two rails were raised
   task automatic t_mid_reset();
      logic [7:0] d;
      wr_keyed(SW_LDO_ADDR, 8'h33, 8'h00, 8'h00, 1'b0);
      strobe(4'h3);
      chk_en(4'h3);
      @(posedge clk_in);
      nrst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      #1 chk_en(4'h0);
      reg_rd(STATUS_ADDR, d);
      chk8(d, 8'h00, "status after reset");
      t_reset_values();
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // watchdog on the whole run
   initial begin
      repeat (20000) @(posedge clk_in);
      mismatches++;
      $display("wrong value at %0t: run did not finish", $time);
      final_report();
   end

   // main sequence
   initial begin
      repeat (5) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_reset_values();
      t_reset_walk();
      t_locked_write();
      t_code_sweep();
      t_mid_reset();
      final_report();
   end
endmodule
